// >>> hdl/sysopt_regs.sv
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Clock select: 0 slow oscillator, 1 bus
// - Window mode: service only in last quarter
// - Early service write in window forces reset
// - Write-once bits take only first write
// - Bit two enables serial port A filter
// - Bit one enables serial port B filter
// - Bit zero routes comparator to timer
// - High id: reserved nibble, part number upper
// - Low id: lower eight part bits
// - Warning flag sets and stays latched
// - Ack clears flag only if warning gone
// - Interrupt request while flag and enable
// - Brownout reset needs detect logic enable
// - Stop enable keeps detection in stop
// - Logic enable gates other detect bits
// - Bandgap buffer enable output
// - Partial power-down flag after stop2 recovery
// - Ack writes clear partial power-down flag
// - Control selects stop3 or stop2 once
// - Threshold selects drive trip points
// - Timeout from clock and field, zero off
module sysopt_regs
    import sysopt_pkg::*;
(
    // AHB-Lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Reset cause and supply conditions
    input  wire logic        por_event,
    input  wire logic        low_supply_warn,
    input  wire logic        brownout_detect,
    input  wire logic        stop_active,
    input  wire logic        stop2_recovered,
    input  wire logic        comparator_out,
    // Option and power controls
    output logic             serial_port_a_filter_enable,
    output logic             serial_port_b_filter_enable,
    output logic             timer_capture_in,
    output logic             bandgap_buffer_enable,
    output logic             brownout_active,
    output logic             brownout_threshold_select,
    output logic             warning_threshold_select,
    output logic             stop2_select,
    output logic             supply_warning_irq,
    output logic             system_reset_req
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: three stages, change accepted on agreement
    logic [4:0] s1_q, s2_q, s3_q, clean_q;
    logic [4:0] raw;
    assign raw = {comparator_out, stop2_recovered, stop_active,
                  brownout_detect, low_supply_warn};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            clean_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < 5; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    clean_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic warn_in, bo_in, stop_in, rec_in, cmp_in;
    assign {cmp_in, rec_in, stop_in, bo_in, warn_in} = clean_q;

    ////////////////////////////////////////////////////////////////////////
    // Selects that survive all but power-on reset
    logic sel_q, sel_d;
    logic wsel_q, wsel_d;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic        ph_wr;
        logic        ph_rd;
        logic [7:0]  ph_ofs;
        logic [31:0] rdata;
        logic [7:0]  opt;
        logic        opt_done;
        logic [1:0]  tmo;
        logic        tmo_done;
        logic        warn_flag;
        logic        warn_ie;
        logic        bo_rst;
        logic        bo_stop;
        logic        bo_en;
        logic        bg_buf;
        logic        p1_done;
        logic        ppd_flag;
        logic        ppd_ctrl;
        logic        ppd_done;
        logic        svc_armed;
        logic [16:0] lpo_cnt;
        logic [17:0] wd_cnt;
        logic        rst_req;
        logic        bo_hit;
    } state_t;

    state_t st_q, st_d;

    // Timeout length in source cycles, zero means disabled
    function automatic logic [17:0] wd_limit(input logic clk_bus,
                                             input logic [1:0] t);
        logic [17:0] r;
        r = '0;
        unique case ({clk_bus, t})
            3'b001: r = 18'd32;
            3'b010: r = 18'd256;
            3'b011: r = 18'd1024;
            3'b101: r = 18'd8192;
            3'b110: r = 18'd65535;
            3'b111: r = 18'h3ffff;
            default: r = '0;
        endcase
        return r;
    endfunction

    logic [17:0] limit;
    logic        wd_tick, wd_win_open, wd_expire, acc;
    logic [7:0]  wb;

    always_comb begin
        st_d    = st_q;
        sel_d   = sel_q;
        wsel_d  = wsel_q;
        wb      = hwdata[7:0];
        acc     = hsel && hready && (htrans == HTRANS_NONSEQ);
        st_d.rst_req = 1'b0;

        // Low-power oscillator tick divider
        // source select
        if (st_q.lpo_cnt == 17'(LPO_DIV - 1)) begin
            st_d.lpo_cnt = '0;
        end else begin
            st_d.lpo_cnt = st_q.lpo_cnt + 17'd1;
        end
        wd_tick = st_q.opt[OPT_WDOG_CLK] ? 1'b1
                                          : (st_q.lpo_cnt == '0);

        limit       = wd_limit(st_q.opt[OPT_WDOG_CLK], st_q.tmo);
        wd_win_open = (st_q.wd_cnt >= (limit - (limit >> 2)));
        wd_expire   = (limit != '0) && (st_q.wd_cnt >= limit);
        if (limit != '0 && wd_tick) begin
            st_d.wd_cnt = st_q.wd_cnt + 18'd1;
        end
        if (wd_expire) begin
            st_d.rst_req = 1'b1;
            st_d.wd_cnt  = '0;
        end

        // Data phase: writes land here
        if (st_q.ph_wr) begin
            unique case (st_q.ph_ofs)
                OFS_OPTIONS_TWO: begin
                    if (!st_q.opt_done) begin
                        st_d.opt[OPT_WDOG_CLK] = wb[OPT_WDOG_CLK];
                        st_d.opt[OPT_WDOG_WIN] = wb[OPT_WDOG_WIN];
                        st_d.opt_done          = 1'b1;
                    end
                    // Filter and route bits stay writable
                    st_d.opt[OPT_SPI_A_FILT] = wb[OPT_SPI_A_FILT];
                    st_d.opt[OPT_SPI_B_FILT] = wb[OPT_SPI_B_FILT];
                    st_d.opt[OPT_CMP_ROUTE]  = wb[OPT_CMP_ROUTE];
                end
                OFS_WDOG_SETUP: begin
                    if (!st_q.tmo_done) begin
                        st_d.tmo      = wb[1:0];
                        st_d.tmo_done = 1'b1;
                    end
                end
                OFS_WDOG_SERVICE: begin
                    if (st_q.opt[OPT_WDOG_WIN] && limit != '0
                        && !wd_win_open) begin
                        st_d.rst_req = 1'b1;
                    end else if (wb == SVC_FIRST) begin
                        st_d.svc_armed = 1'b1;
                    end else if (wb == SVC_SECOND && st_q.svc_armed) begin
                        st_d.svc_armed = 1'b0;
                        st_d.wd_cnt    = '0;
                    end else begin
                        st_d.svc_armed = 1'b0;
                    end
                end
                OFS_POWER_ONE: begin
                    if (wb[P1_WARN_ACK] && !warn_in) begin
                        st_d.warn_flag = 1'b0;
                    end
                    st_d.warn_ie = wb[P1_WARN_IE];
                    st_d.bo_stop = wb[P1_BO_STOP];
                    st_d.bg_buf  = wb[P1_BG_BUF];
                    if (!st_q.p1_done) begin
                        st_d.bo_rst  = wb[P1_BO_RST];
                        st_d.bo_en   = wb[P1_BO_EN];
                        st_d.p1_done = 1'b1;
                    end
                end
                OFS_POWER_TWO: begin
                    sel_d  = wb[P2_BO_SEL];
                    wsel_d = wb[P2_WARN_SEL];
                    if (wb[P2_PPD_ACK]) begin
                        st_d.ppd_flag = 1'b0;
                    end
                    if (!st_q.ppd_done) begin
                        st_d.ppd_ctrl = wb[P2_PPD_CTRL];
                        st_d.ppd_done = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (warn_in) begin
            st_d.warn_flag = 1'b1;
        end
        if (rec_in) begin
            st_d.ppd_flag = 1'b1;
        end

        // gated brownout reset
        // Request on the event edge so the request stays a pulse
        st_d.bo_hit = bo_in && st_q.bo_en && st_q.bo_rst
                      && (!stop_in || st_q.bo_stop);
        if (st_d.bo_hit && !st_q.bo_hit) begin
            st_d.rst_req = 1'b1;
        end

        // Address phase capture and read data
        st_d.ph_wr  = acc && hwrite;
        st_d.ph_rd  = acc && !hwrite;
        st_d.ph_ofs = haddr[7:0];
        st_d.rdata  = '0;
        if (acc && !hwrite) begin
            unique case (haddr[7:0])
                OFS_OPTIONS_TWO:  st_d.rdata[7:0] = st_q.opt;
                OFS_PART_ID_HIGH: st_d.rdata[7:0] = {ID_RSVD,
                                                     PART_NUMBER[11:8]};
                OFS_PART_ID_LOW:  st_d.rdata[7:0] = PART_NUMBER[7:0];
                OFS_POWER_ONE:    st_d.rdata[7:0] = {st_q.warn_flag, 1'b0,
                                  st_q.warn_ie, st_q.bo_rst, st_q.bo_stop,
                                  st_q.bo_en, 1'b0, st_q.bg_buf};
                OFS_POWER_TWO:    st_d.rdata[7:0] = {2'b00, sel_q, wsel_q,
                                  st_q.ppd_flag, 2'b00, st_q.ppd_ctrl};
                OFS_WDOG_SETUP:   st_d.rdata[7:0] = {6'd0, st_q.tmo};
                default:          st_d.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main register, loaded with its reset values (not all zero) by every reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q          <= '0;
            st_q.opt      <= OPT_RESET;
            st_q.tmo      <= TMO_RESET;
            st_q.bo_rst   <= P1_RESET[P1_BO_RST];
            st_q.bo_stop  <= P1_RESET[P1_BO_STOP];
            st_q.bo_en    <= P1_RESET[P1_BO_EN];
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge hclk) begin
        if (por_event) begin
            sel_q  <= 1'b0;
            wsel_q <= 1'b0;
        end else begin
            sel_q  <= sel_d;
            wsel_q <= wsel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hrdata    = st_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign serial_port_a_filter_enable = st_q.opt[OPT_SPI_A_FILT];
    assign serial_port_b_filter_enable = st_q.opt[OPT_SPI_B_FILT];
    assign timer_capture_in = st_q.opt[OPT_CMP_ROUTE] & cmp_in;
    assign bandgap_buffer_enable = st_q.bg_buf;
    assign brownout_active = st_q.bo_en & (!stop_in | st_q.bo_stop);
    assign brownout_threshold_select = sel_q;
    assign warning_threshold_select  = wsel_q;
    assign stop2_select = st_q.ppd_ctrl;
    assign supply_warning_irq = st_q.warn_flag & st_q.warn_ie;
    assign system_reset_req   = st_q.rst_req;

endmodule

// >>> pkg/sysopt_pkg.sv
package sysopt_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_OPTIONS_TWO  = 8'h00;
    localparam logic [7:0] OFS_PART_ID_HIGH = 8'h04;
    localparam logic [7:0] OFS_PART_ID_LOW  = 8'h08;
    localparam logic [7:0] OFS_POWER_ONE    = 8'h0c;
    localparam logic [7:0] OFS_POWER_TWO    = 8'h10;
    localparam logic [7:0] OFS_WDOG_SERVICE = 8'h14;
    localparam logic [7:0] OFS_WDOG_SETUP   = 8'h18;

    // Options register fields
    localparam int OPT_WDOG_CLK   = 7;
    localparam int OPT_WDOG_WIN   = 6;
    localparam int OPT_SPI_A_FILT = 2;
    localparam int OPT_SPI_B_FILT = 1;
    localparam int OPT_CMP_ROUTE  = 0;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [7:0] OPT_MASK  = 8'hc7;

    // Power register one fields
    localparam int P1_WARN_FLAG = 7;
    localparam int P1_WARN_ACK  = 6;
    localparam int P1_WARN_IE   = 5;
    localparam int P1_BO_RST    = 4;
    localparam int P1_BO_STOP   = 3;
    localparam int P1_BO_EN     = 2;
    localparam int P1_BG_BUF    = 0;
    localparam logic [7:0] P1_RESET = 8'h1c;

    // Power register two fields
    localparam int P2_BO_SEL    = 5;
    localparam int P2_WARN_SEL  = 4;
    localparam int P2_PPD_FLAG  = 3;
    localparam int P2_PPD_ACK   = 2;
    localparam int P2_PPD_CTRL  = 0;

    // Identification (value arbitrary)
    localparam logic [11:0] PART_NUMBER = 12'h5a3;
    localparam logic [3:0]  ID_RSVD     = 4'h0;

    // Watchdog service sequence bytes and timeout field reset
    localparam logic [7:0] SVC_FIRST   = 8'h55;
    localparam logic [7:0] SVC_SECOND  = 8'haa;
    localparam logic [1:0] TMO_RESET   = 2'b11;

    // Low-power oscillator: 1 kHz tick derived from 125 MHz
    localparam int CLK_HZ  = 125_000_000;
    localparam int LPO_HZ  = 1_000;
    localparam int LPO_DIV = CLK_HZ / LPO_HZ;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// >>> dv/sysopt_regs_asserts.sv
`timescale 1ns/1ps
module sysopt_regs_asserts
    import sysopt_pkg::*;
(
    // Bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic        por_event,
    input wire logic        comparator_out,
    input wire logic        serial_port_a_filter_enable,
    input wire logic        timer_capture_in,
    input wire logic        bandgap_buffer_enable,
    input wire logic        brownout_threshold_select,
    input wire logic        system_reset_req
);
    // Accepted address phases
    logic       acc;
    logic       rd;
    logic [7:0] a;
    assign acc = hsel && hready && htrans == HTRANS_NONSEQ;
    assign rd  = acc && !hwrite;
    assign a   = haddr[7:0];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_id_low;
        rd && a == OFS_PART_ID_LOW |=> hrdata[7:0] == PART_NUMBER[7:0];
    endproperty
    a_id_low: assert property (p_id_low) else $error("id low");
    property p_id_high;
        rd && a == OFS_PART_ID_HIGH |=> hrdata[3:0] == PART_NUMBER[11:8];
    endproperty
    a_id_high: assert property (p_id_high) else $error("id high");
    property p_p2_zero;
        rd && a == OFS_POWER_TWO |=> hrdata[7:6] == 0 && hrdata[2:1] == 0;
    endproperty
    a_p2_zero: assert property (p_p2_zero) else $error("p2 bits");
    // Sync chain is shorter than eight cycles
    property p_cmp;
        !comparator_out [*8] |=> !timer_capture_in;
    endproperty
    a_cmp: assert property (p_cmp) else $error("capture");
    property p_filt;
        $changed(serial_port_a_filter_enable)
            |-> $past(acc && hwrite && a == OFS_OPTIONS_TWO, 2);
    endproperty
    a_filt: assert property (p_filt) else $error("filter a");
    property p_bgap;
        $changed(bandgap_buffer_enable)
            |-> $past(acc && hwrite && a == OFS_POWER_ONE, 2);
    endproperty
    a_bgap: assert property (p_bgap) else $error("bandgap");
    // Checked inside reset, so no disable here
    property p_sel_keep;
        disable iff (1'b0)
        (!hresetn && !por_event) [*6] |=> $stable(brownout_threshold_select);
    endproperty
    a_sel_keep: assert property (p_sel_keep) else $error("sel lost");
    property p_pulse;
        system_reset_req |=> !system_reset_req;
    endproperty
    a_pulse: assert property (p_pulse) else $error("req width");
endmodule

////////////////////////////////////////
bind sysopt_regs sysopt_regs_asserts u_sysopt_regs_asserts (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .por_event, .comparator_out, .serial_port_a_filter_enable,
    .timer_capture_in, .bandgap_buffer_enable, .brownout_threshold_select,
    .system_reset_req
);

// >>> dv/sysopt_regs_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
    $display("unexpected %s exp %h seen %h", n, e, s); end end
module sysopt_regs_bench;
    import sysopt_pkg::*;
    // Bus and pins
    logic        hclk, hresetn, hsel, hwrite, hready, por_event, rd_ph;
    logic        low_supply_warn, brownout_detect, stop_active;
    logic        stop2_recovered, comparator_out, hreadyout, hresp;
    logic        fa, fb, tci, bg, ba, bts, wts, s2, irq, rq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] q[$];
    logic [15:0] ex;
    logic [7:0]  v;
    int          fails, cmp_count, seed, n;

    assign hready = hreadyout;
    sysopt_regs u_sysopt_regs (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .por_event, .low_supply_warn,
        .brownout_detect, .stop_active, .stop2_recovered, .comparator_out,
        .serial_port_a_filter_enable(fa), .serial_port_b_filter_enable(fb),
        .timer_capture_in(tci), .bandgap_buffer_enable(bg),
        .brownout_active(ba), .brownout_threshold_select(bts),
        .warning_threshold_select(wts), .stop2_select(s2),
        .supply_warning_irq(irq), .system_reset_req(rq)
    );

    ////////////////////////////////////////
    task automatic rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
    endtask
    // Single word transfer, low byte carries the register
    task automatic bus(input logic w, input logic [7:0] a, d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        rdy();
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, m, e);
        q.push_back({m, e & m});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    // Bounded wait for a reset request; n is the cycles spent
    task automatic wreq(input int lim);
        n = 0;
        while (rq !== 1'b1 && n < lim) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic rst(input logic p);
        hresetn   <= 1'b0;
        por_event <= p;
        cyc(10);
        hresetn   <= 1'b1;
        por_event <= 1'b0;
        cyc(1);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Read data checked one edge after its address phase
    always @(posedge hclk) begin
        if (rd_ph) begin
            ex = q.pop_front();
            `CHK("hrdata", ex[7:0], hrdata[7:0] & ex[15:8])
        end
        rd_ph <= hresetn && hsel && hready && htrans == HTRANS_NONSEQ
                 && !hwrite;
    end

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // Hang guard, far beyond the watchdog phases
    initial begin
        #1_000_000;
        fails++;
        finish_test();
    end

    initial begin
        {hresetn, hsel, hwrite, por_event, rd_ph} = '0;
        {low_supply_warn, brownout_detect, stop_active} = '0;
        {stop2_recovered, comparator_out} = '0;
        {haddr, hwdata, htrans, fails, cmp_count} = '0;
        hsize = 3'b010;
        seed  = 35470;
        rst(1'b1);
        rd(OFS_OPTIONS_TWO, 8'hff, OPT_RESET);
        rd(OFS_PART_ID_HIGH, 8'h0f, {4'h0, PART_NUMBER[11:8]});
        wr(OFS_PART_ID_LOW, 8'hff);
        rd(OFS_PART_ID_LOW, 8'hff, PART_NUMBER[7:0]);
        rd(OFS_POWER_ONE, 8'hff, P1_RESET);
        wr(8'h1c, 8'hff);
        rd(8'h1c, 8'hff, 8'h00);
        // Options: second write keeps only the plain bits
        v = 8'($random(seed));
        wr(OFS_OPTIONS_TWO, v);
        rd(OFS_OPTIONS_TWO, 8'hff, v & OPT_MASK);
        `CHK("filter_a", v[2], fa)
        `CHK("filter_b", v[1], fb)
        wr(OFS_OPTIONS_TWO, ~v);
        rd(OFS_OPTIONS_TWO, 8'hff, {v[7:6], 3'b000, ~v[2:0]});
        for (int i = 0; i < 4; i++) begin
            wr(OFS_OPTIONS_TWO, {7'h00, i[0]});
            comparator_out <= i[1];
            cyc(8);
            `CHK("capture", i[0] & i[1], tci)
        end
        // Power one controls and brownout gating in stop
        wr(OFS_POWER_ONE, 8'h2d);
        stop_active <= 1'b1;
        cyc(8);
        `CHK("bandgap", 1'b1, bg)
        `CHK("bo_active", 1'b1, ba)
        wr(OFS_POWER_ONE, 8'h21);
        cyc(8);
        `CHK("bo_stop", 1'b0, ba)
        rd(OFS_POWER_ONE, 8'hff, 8'h25);
        stop_active     <= 1'b0;
        low_supply_warn <= 1'b1;
        cyc(8);
        `CHK("irq_on", 1'b1, irq)
        wr(OFS_POWER_ONE, 8'h61);
        rd(OFS_POWER_ONE, 8'h80, 8'h80);
        low_supply_warn <= 1'b0;
        cyc(8);
        rd(OFS_POWER_ONE, 8'h80, 8'h80);
        wr(OFS_POWER_ONE, 8'h61);
        rd(OFS_POWER_ONE, 8'h80, 8'h00);
        `CHK("irq_off", 1'b0, irq)
        wr(OFS_POWER_ONE, 8'h01);
        low_supply_warn <= 1'b1;
        cyc(8);
        `CHK("irq_mask", 1'b0, irq)
        low_supply_warn <= 1'b0;
        // Power two: recovery flag, write-once stop select
        stop2_recovered <= 1'b1;
        cyc(8);
        stop2_recovered <= 1'b0;
        cyc(8);
        rd(OFS_POWER_TWO, 8'h08, 8'h08);
        wr(OFS_POWER_TWO, 8'h35);
        rd(OFS_POWER_TWO, 8'hff, 8'h31);
        `CHK("thresh", 2'b11, {bts, wts})
        wr(OFS_POWER_TWO, 8'h30);
        `CHK("stop2", 1'b1, s2)
        rst(1'b0);
        `CHK("keep_sel", 1'b1, bts)
        rd(OFS_POWER_TWO, 8'hff, 8'h30);
        rst(1'b1);
        rd(OFS_POWER_TWO, 8'hff, 8'h00);
        brownout_detect <= 1'b1;
        wreq(20);
        `CHK("bo_reset", 1'b1, n < 20)
        brownout_detect <= 1'b0;
        cyc(10);
        wr(OFS_POWER_ONE, 8'h10);
        brownout_detect <= 1'b1;
        wreq(20);
        `CHK("bo_gated", 20, n)
        brownout_detect <= 1'b0;
        // Watchdog on bus clock, shortest period, then with the timeout field at zero (off)
        rst(1'b0);
        wr(OFS_OPTIONS_TWO, 8'h80);
        wr(OFS_WDOG_SETUP, 8'h01);
        wreq(9000);
        `CHK("wd_expire", 1'b1, n > 8150 && n < 8250)
        rst(1'b0);
        wr(OFS_OPTIONS_TWO, 8'hc0);
        wr(OFS_WDOG_SETUP, 8'h01);
        cyc(6500);
        wr(OFS_WDOG_SERVICE, SVC_FIRST);
        wr(OFS_WDOG_SERVICE, SVC_SECOND);
        wreq(9000);
        `CHK("wd_window", 1'b1, n > 7000 && n < 9000)
        rst(1'b0);
        wr(OFS_OPTIONS_TWO, 8'hc0);
        wr(OFS_WDOG_SETUP, 8'h01);
        wr(OFS_WDOG_SERVICE, SVC_FIRST);
        wreq(20);
        `CHK("wd_early", 1'b1, n < 20)
        rst(1'b0);
        wr(OFS_OPTIONS_TWO, 8'h80);
        wr(OFS_WDOG_SETUP, 8'h00);
        wreq(9000);
        `CHK("wd_off", 9000, n)
        finish_test();
    end
endmodule
